// ===== sbgpio_cfg_mem.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// per-pin configuration store, lock is set-only
module sbgpio_cfg_mem #(
  parameter int depth = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sb_por,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [3:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [3:0] rd_data,
  output logic [depth-1:0] lock_vec,
  output logic [depth-1:0] oe_vec,
  output logic [depth-1:0] pp_vec,
  output logic [depth-1:0] pu_vec
);
  logic [3:0] mem_r [depth];
  // only standby power-up reloads the store (4h pins 0-5, 5h pins 6-7), main reset leaves it alone
  always_ff @(posedge mclk) begin
    if (sb_por) begin
      for (int i = 0; i < depth; i++) begin
        mem_r[i] <= (i >= 6) ? sbgpio_pkg::cfg_outonly_rst : sbgpio_pkg::cfg_bidir_rst;
      end
    end else if (wr_en) begin
      if (mem_r[wr_idx][sbgpio_pkg::cfg_lock_bit]) begin
        mem_r[wr_idx] <= mem_r[wr_idx];
      end else begin
        mem_r[wr_idx] <= wr_data;
        if (wr_idx >= 3'd6) begin
          mem_r[wr_idx][sbgpio_pkg::cfg_oe_bit] <= 1'b1;
        end
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rd_data <= 4'h0;
    end else begin
      rd_data <= mem_r[rd_idx];
    end
  end
  always_comb begin
    for (int i = 0; i < depth; i++) begin
      lock_vec[i] = mem_r[i][sbgpio_pkg::cfg_lock_bit];
      oe_vec[i] = mem_r[i][sbgpio_pkg::cfg_oe_bit];
      pp_vec[i] = mem_r[i][sbgpio_pkg::cfg_pushpull_bit];
      pu_vec[i] = mem_r[i][sbgpio_pkg::cfg_pullup_bit];
    end
  end
endmodule
`default_nettype wire

// ===== sbgpio_data_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - bidir latch loads 3fh when unlocked
// - latch bits 5-0 drive bidir pins
// - locked bits ignore writes
// - latch reads return stored value
// - zero drives low, one per buffer type
// - input reg shows live pin levels
// - input read ignores config and latch
// - input registers are read-only
// - output-only latch loads 03h when unlocked
// - latch bits 1-0 drive output-only pins
// - second input reg shows four pins
// - bidir latch bits 7-6 reserved zero
// - lock stays set until standby reset
module sbgpio_data_regs (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sw_reset,
  input wire logic sb_por,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [5:0] bidir_pin_i,
  output logic [5:0] bidir_pin_o,
  output logic [5:0] bidir_pin_oe,
  output logic [5:0] bidir_pullup,
  input wire logic [1:0] input_only_pin_i,
  input wire logic [1:0] event_input_pin_i,
  input wire logic [1:0] outonly_pin_i,
  output logic [1:0] outonly_pin_o,
  output logic [1:0] outonly_pin_oe,
  output logic [1:0] outonly_pullup
);
  // ==========================================
  // configuration select and store
  logic [2:0] cfg_sel_r;
  logic [3:0] cfg_rd;
  logic [7:0] lock_vec, oe_vec, pp_vec, pu_vec;
  logic cfg_wr;
  assign cfg_wr = wr && (addr == sbgpio_pkg::cfg_data_off);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cfg_sel_r <= 3'h0;
    end else if (wr && addr == sbgpio_pkg::cfg_sel_off) begin
      cfg_sel_r <= wdata[2:0];
    end
  end

  sbgpio_cfg_mem #(.depth(sbgpio_pkg::npins)) u_cfg (
    .mclk(mclk),
    .rst_b(rst_b),
    .sb_por(sb_por),
    .wr_en(cfg_wr),
    .wr_idx(cfg_sel_r),
    .wr_data(wdata[3:0]),
    .rd_idx(cfg_sel_r),
    .rd_data(cfg_rd),
    .lock_vec(lock_vec),
    .oe_vec(oe_vec),
    .pp_vec(pp_vec),
    .pu_vec(pu_vec)
  );

  // ==========================================
  // output latches
  logic [5:0] bidir_out_r;
  logic [1:0] outonly_out_r;
  logic main_rst;
  assign main_rst = !rst_b || sw_reset;

  // per bit: lock wins over both reset and write
  function automatic logic [7:0] latch_nxt(input logic [7:0] cur, input logic [7:0] rstv,
      input logic [7:0] wv, input logic do_rst, input logic do_wr, input logic [7:0] lk);
    logic [7:0] r;
    r = cur;
    for (int i = 0; i < 8; i++) begin
      if (!lk[i] && do_rst) begin
        r[i] = rstv[i];
      end else if (!lk[i] && do_wr) begin
        r[i] = wv[i];
      end
    end
    return r;
  endfunction

  // latches sit in the standby domain: no plain reset term, only the unlocked load
  logic [7:0] bidir_tmp, outonly_tmp;
  assign bidir_tmp = latch_nxt({2'h0, bidir_out_r}, {2'h0, sbgpio_pkg::bidir_out_rst},
      wdata, main_rst, wr && addr == sbgpio_pkg::bidir_out_off, {2'h3, lock_vec[5:0]});
  assign outonly_tmp = latch_nxt({6'h0, outonly_out_r}, {6'h0, sbgpio_pkg::outonly_out_rst},
      wdata, main_rst, wr && addr == sbgpio_pkg::outonly_out_off, {6'h3f, lock_vec[7:6]});

  always_ff @(posedge mclk) begin
    if (sb_por) begin
      bidir_out_r <= sbgpio_pkg::bidir_out_rst;
    end else begin
      bidir_out_r <= bidir_tmp[5:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sb_por) begin
      outonly_out_r <= sbgpio_pkg::outonly_out_rst;
    end else begin
      outonly_out_r <= outonly_tmp[1:0];
    end
  end

  // ==========================================
  // pin drive, registered
  function automatic logic drv(input logic d, input logic pp);
    return d ? pp : 1'b1;
  endfunction

  always_ff @(posedge mclk) begin
    if (sb_por) begin
      bidir_pin_o <= 6'h0;
      bidir_pin_oe <= 6'h0;
      bidir_pullup <= 6'h3f;
    end else begin
      for (int i = 0; i < 6; i++) begin
        bidir_pin_o[i] <= bidir_out_r[i];
        // open-drain releases the pin for a one
        bidir_pin_oe[i] <= oe_vec[i] && drv(bidir_out_r[i], pp_vec[i]);
        bidir_pullup[i] <= pu_vec[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sb_por) begin
      outonly_pin_o <= 2'h3;
      outonly_pin_oe <= 2'h0;
      outonly_pullup <= 2'h3;
    end else begin
      for (int i = 0; i < 2; i++) begin
        outonly_pin_o[i] <= outonly_out_r[i];
        outonly_pin_oe[i] <= oe_vec[6+i] && drv(outonly_out_r[i], pp_vec[6+i]);
        outonly_pullup[i] <= pu_vec[6+i];
      end
    end
  end

  // ==========================================
  // read path; writes to input offsets match no write decode
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdata <= 8'h0;
    end else if (rd) begin
      if (addr == sbgpio_pkg::bidir_out_off) begin
        rdata <= {2'h0, bidir_out_r};
      end else if (addr == sbgpio_pkg::bidir_in_off) begin
        rdata <= {event_input_pin_i, bidir_pin_i};
      end else if (addr == sbgpio_pkg::outonly_out_off) begin
        rdata <= {6'h0, outonly_out_r};
      end else if (addr == sbgpio_pkg::outonly_in_off) begin
        rdata <= {4'h0, input_only_pin_i, outonly_pin_i};
      end else if (addr == sbgpio_pkg::cfg_sel_off) begin
        rdata <= {5'h0, cfg_sel_r};
      end else if (addr == sbgpio_pkg::cfg_data_off) begin
        // store read port is registered, so a fresh select shows one cycle later
        rdata <= {4'h0, cfg_rd};
      end else begin
        rdata <= 8'h0;
      end
    end else begin
      rdata <= 8'h0;
    end
  end
endmodule
`default_nettype wire

// ===== sbgpio_data_regs_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// port checks for the standby data registers
module sbgpio_data_regs_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sb_por,
  input wire logic [7:0] addr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [5:0] bidir_pin_i,
  input wire logic [1:0] input_only_pin_i,
  input wire logic [1:0] event_input_pin_i,
  input wire logic [1:0] outonly_pin_i,
  input wire logic [5:0] bidir_pin_o,
  input wire logic [1:0] outonly_pin_o
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_rd(a);
    rd && addr == a;
  endsequence
  chk_in0_levels: assert property (s_rd(8'h09) |=>
    rdata == {$past(event_input_pin_i), $past(bidir_pin_i)}) else $error("in0 read wrong");
  chk_in1_levels: assert property (s_rd(8'h0b) |=>
    rdata == {4'h0, $past(input_only_pin_i), $past(outonly_pin_i)}) else $error("in1 read wrong");
  chk_bidir_rsvd: assert property (s_rd(8'h08) |=> rdata[7:6] == 2'h0)
    else $error("bidir reserved set");
  chk_outonly_rsvd: assert property (s_rd(8'h0a) |=> rdata[7:2] == 6'h00)
    else $error("outonly reserved set");
  chk_bidir_latch: assert property (s_rd(8'h08) |=> rdata[5:0] == bidir_pin_o)
    else $error("bidir latch mismatch");
  chk_outonly_latch: assert property (s_rd(8'h0a) |=> rdata[1:0] == outonly_pin_o)
    else $error("outonly latch mismatch");
  chk_unmapped_zero: assert property (rd && addr > 8'h0d |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_por_reload: assert property ($fell(sb_por) |=>
    bidir_pin_o == 6'h3f && outonly_pin_o == 2'h3) else $error("por reload wrong");
endmodule
bind sbgpio_data_regs sbgpio_data_regs_chk sbgpio_data_regs_chk_i (.mclk, .rst_b, .sb_por,
  .addr, .rd, .rdata, .bidir_pin_i, .input_only_pin_i, .event_input_pin_i, .outonly_pin_i,
  .bidir_pin_o, .outonly_pin_o);
`default_nettype wire

// ===== sbgpio_pins_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// pins: an enabled buffer wins, else the outside level or the pull-up
module sbgpio_pins_model (
  input wire logic [5:0] bidir_pin_o,
  input wire logic [5:0] bidir_pin_oe,
  input wire logic [1:0] outonly_pin_o,
  input wire logic [1:0] outonly_pin_oe,
  input wire logic [5:0] ext_lvl,
  output logic [5:0] bidir_pin_i,
  output logic [1:0] outonly_pin_i
);
  assign bidir_pin_i = (bidir_pin_oe & bidir_pin_o) | (~bidir_pin_oe & ext_lvl);
  assign outonly_pin_i = (outonly_pin_oe & outonly_pin_o) | ~outonly_pin_oe;
endmodule
`default_nettype wire

// ===== sbgpio_pkg.sv
`default_nettype none
package sbgpio_pkg;
  localparam logic [7:0] bidir_out_off = 8'h08;
  localparam logic [7:0] bidir_in_off = 8'h09;
  localparam logic [7:0] outonly_out_off = 8'h0a;
  localparam logic [7:0] outonly_in_off = 8'h0b;
  localparam logic [7:0] cfg_sel_off = 8'h0c;
  localparam logic [7:0] cfg_data_off = 8'h0d;
  localparam logic [5:0] bidir_out_rst = 6'h3f;
  localparam logic [1:0] outonly_out_rst = 2'h3;
  localparam int cfg_lock_bit = 3;
  localparam int cfg_pullup_bit = 2;
  localparam int cfg_pushpull_bit = 1;
  localparam int cfg_oe_bit = 0;
  localparam logic [3:0] cfg_bidir_rst = 4'h4;
  localparam logic [3:0] cfg_outonly_rst = 4'h5;
  localparam int npins = 8;
endpackage
`default_nettype wire

// ===== standby_gpio_data_registers_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module standby_gpio_data_registers_tb_top;
  logic mclk = 0, rst_b = 0, sw_reset = 0, sb_por = 1, wr = 0, rd = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [5:0] bp_i, bp_o, bp_oe, ext_lvl = 6'h00;
  logic [1:0] io_i = 2'h0, ev_i = 2'h0, op_i, op_o, op_oe;
  logic [5:0] bp_pu;
  logic [1:0] op_pu;
  int bad_count = 0, checks = 0;
  always #2.5 mclk = ~mclk;
  sbgpio_data_regs sbgpio_data_regs_i (.mclk, .rst_b, .sw_reset, .sb_por, .addr, .wdata,
    .wr, .rd, .rdata, .bidir_pin_i(bp_i), .bidir_pin_o(bp_o), .bidir_pin_oe(bp_oe),
    .bidir_pullup(bp_pu), .input_only_pin_i(io_i), .event_input_pin_i(ev_i),
    .outonly_pin_i(op_i), .outonly_pin_o(op_o), .outonly_pin_oe(op_oe),
    .outonly_pullup(op_pu));
  sbgpio_pins_model sbgpio_pins_model_i (.bidir_pin_o(bp_o), .bidir_pin_oe(bp_oe),
    .outonly_pin_o(op_o), .outonly_pin_oe(op_oe), .ext_lvl, .bidir_pin_i(bp_i),
    .outonly_pin_i(op_i));
  // ==========
  // bus tasks: each starts just after an edge and leaves one idle edge behind it, pulse leaves two
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr <= 1; addr <= a; wdata <= d;
    @(posedge mclk) wr <= 0;
    @(posedge mclk);
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rd <= 1; addr <= a;
    @(posedge mclk) rd <= 0;
    #1 chk(rdata, exp);
    @(posedge mclk);
  endtask
  task pulse(input int which);
    if (which == 0) sw_reset <= 1; else sb_por <= 1;
    @(posedge mclk) begin sw_reset <= 0; sb_por <= 0; end
    repeat (2) @(posedge mclk);
  endtask
  // ==========
  // scenarios
  task t_reset;
    rd_chk(8'h08, 8'h3f);
    rd_chk(8'h0a, 8'h03);
    chk({2'h0, bp_oe}, 8'h00);
    chk({2'h0, bp_pu}, 8'h3f);
    chk({6'h00, op_pu}, 8'h03);
    $display("test reset done");
  endtask
  task t_latch;
    wr_reg(8'h08, 8'hea); rd_chk(8'h08, 8'h2a);
    chk({2'h0, bp_o}, 8'h2a);
    wr_reg(8'h0a, 8'hfd); rd_chk(8'h0a, 8'h01);
    chk({6'h00, op_o}, 8'h01);
    chk({6'h00, op_oe}, 8'h02);
    $display("test latch done");
  endtask
  task t_inputs;
    ext_lvl <= 6'h15; ev_i <= 2'h2; io_i <= 2'h1;
    @(posedge mclk);
    rd_chk(8'h09, 8'h95);
    wr_reg(8'h09, 8'h00); rd_chk(8'h09, 8'h95);
    rd_chk(8'h0b, 8'h05);
    wr_reg(8'h0b, 8'hff); rd_chk(8'h0b, 8'h05);
    rd_chk(8'h20, 8'h00);
    $display("test inputs done");
  endtask
  task t_lock;
    wr_reg(8'h08, 8'h00); wr_reg(8'h0c, 8'h01); wr_reg(8'h0d, 8'h08);
    wr_reg(8'h08, 8'h3f); rd_chk(8'h08, 8'h3d);
    wr_reg(8'h08, 8'h00); pulse(0); rd_chk(8'h08, 8'h3d);
    pulse(1); rd_chk(8'h08, 8'h3f);
    wr_reg(8'h08, 8'h00); rd_chk(8'h08, 8'h00);
    $display("test lock done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    sb_por <= 0; rst_b <= 1;
    repeat (2) @(posedge mclk);
    t_reset;
    t_latch;
    t_inputs;
    t_lock;
    final_report;
  end
endmodule
`default_nettype wire
